//--- ac_alarm_device.sv
// Far-end alarm code device: transmitter, detector, queue and registers
//
// Contract
// - T3 needs C-bit parity; E3 may use Sn
// - Receive always on; Sn source host selected (code: receiver off in T3 without C-bit parity)
// - Word: eight ones, zero, six data, zero
// - Each sent word repeats ten times minimum
// - Send all ones when no word sent
// - Bitwise search, validate after three identical
// - Validated word lost after two bad
// - Validation sets detect flag, queues data
// - Receive queue holds four entries
// - Full queue drops word, sets overflow
// - Control bits 0-5 word A, LSB first
// - Control bits 8-13 word B, LSB first
// - Select: ones, 10A, 10A+10B, continuous A
// - Select acts on change; host returns 00
// - Host waits ten words idle first
// - Host changes data only while idle
// - Bit 15 rising edge resets receiver
// - Detect flag latched, clear on read, interrupts
// - Idle flag after sixteen ones, gated
// - Status 8-13 show oldest queue entry
// - Status 14 shows queue empty live
// - Overflow flag rearms only after read
//
// Added by the designer: register access over APB.
`include "ac_alarm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ac_alarm_device import ac_pkg::*; (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Controller side
    ac_link_if.dev link,
    // Framer mode
    input wire logic t3_mode_in,
    input wire logic cbit_parity_in,
    input wire logic [1:0] sn_source_sel_in,
    // Framer alarm channel
    input wire logic tx_bit_en_in,
    output logic tx_bit_out,
    output logic sn_from_alarm_out,
    input wire logic rx_bit_en_in,
    input wire logic rx_bit_in
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [1:0] sel_prev;
        logic go;
        logic [1:0] go_sel;
        ac_tx_t tx_st;
        logic [3:0] tx_idx;
        logic [3:0] tx_reps;
        logic tx_bit;
        logic [15:0] rx_sh;
        logic [3:0] rx_phase;
        logic rx_lock;
        logic [5:0] rx_cand;
        logic [1:0] rx_hits;
        logic rx_valid;
        logic [1:0] rx_miss;
        logic [4:0] rx_ones;
        logic rx_seen;
        logic [3:0][5:0] q;
        logic [1:0] q_rd;
        logic [2:0] q_cnt;
        logic ovf_arm;
        logic det;
        logic idle;
        logic ovf;
        logic [15:0] rdata;
        logic ack;
    } ac_dev_state_t;

    ac_dev_state_t s;
    ac_dev_state_t next_s;
    logic on;
    logic take;
    logic [15:0] word;
    logic [15:0] sh;
    logic match;
    logic [1:0] wr_idx;

    ////////////////////////
    // Channel enable and outputs
    assign on = t3_mode_in ? cbit_parity_in : 1'b1;
    assign sn_from_alarm_out = !t3_mode_in && (sn_source_sel_in == `AC_SN_FROM_ALARM);
    assign tx_bit_out = s.tx_bit;
    assign link.reg_rdata = s.rdata;
    assign link.reg_ack = s.ack;
    // Interrupt request from latched flags
    assign link.alarm_irq = link.master_irq_mask &&
        (s.det || (s.idle && s.ctrl[`AC_IDLE_IE_BIT]));
    assign take = (link.reg_wr || link.reg_rd) && !s.ack;

    ////////////////////////
    // Next-state logic
    always_comb begin
        next_s = s;
        word = 16'h0000;
        sh = 16'h0000;
        match = 1'b0;
        wr_idx = 2'h0;
        next_s.ack = take;
        next_s.sel_prev = s.ctrl[`AC_SEL_LSB +: 2];
        // Select acts on a change to non-idle
        if (s.ctrl[`AC_SEL_LSB +: 2] != s.sel_prev && s.ctrl[`AC_SEL_LSB +: 2] != 2'h0) begin
            next_s.go = 1'b1;
            next_s.go_sel = s.ctrl[`AC_SEL_LSB +: 2];
        end
        // Reads, clears and pops before events
        if (take && link.reg_rd) begin
            if (link.reg_addr == `AC_CTRL_OFS) begin
                next_s.rdata = s.ctrl;
            end else if (link.reg_addr == `AC_STAT_OFS) begin
                next_s.rdata = 16'h0000;
                next_s.rdata[`AC_DET_BIT] = s.det;
                next_s.rdata[`AC_IDLE_BIT] = s.idle;
                next_s.rdata[`AC_Q_LSB +: 6] = s.q[s.q_rd];
                next_s.rdata[`AC_EMPTY_BIT] = (s.q_cnt == 3'h0);
                next_s.rdata[`AC_OVF_BIT] = s.ovf;
                next_s.det = 1'b0;
                next_s.idle = 1'b0;
                next_s.ovf = 1'b0;
                if (s.q_cnt != 3'h0) begin
                    next_s.q_rd = s.q_rd + 2'h1;
                    next_s.q_cnt = s.q_cnt - 3'h1;
                    next_s.ovf_arm = 1'b1;
                end
            end else begin
                next_s.rdata = 16'h0000;
            end
        end
        if (take && link.reg_wr && link.reg_addr == `AC_CTRL_OFS) begin
            next_s.ctrl = link.reg_wdata;
        end
        // Transmitter, one bit per opportunity
        if (tx_bit_en_in && on) begin
            if (s.tx_st == TX_IDLE && s.go) begin
                next_s.go = 1'b0;
                next_s.tx_idx = 4'h0;
                next_s.tx_reps = 4'h0;
                unique case (ac_sel_t'(s.go_sel))
                    AC_SEL_A10: next_s.tx_st = TX_A;
                    AC_SEL_AB10: next_s.tx_st = TX_AB;
                    AC_SEL_ACONT: next_s.tx_st = TX_CONT;
                    AC_SEL_IDLE: next_s.tx_st = TX_IDLE;
                endcase
            end
            word = (next_s.tx_st == TX_B) ? ac_word(s.ctrl[`AC_WB_LSB +: 6]) :
                ac_word(s.ctrl[`AC_WA_LSB +: 6]);
            next_s.tx_bit = (next_s.tx_st == TX_IDLE) ? 1'b1 : word[next_s.tx_idx];
            if (next_s.tx_st != TX_IDLE) begin
                next_s.tx_idx = next_s.tx_idx + 4'h1;
                if (next_s.tx_idx == 4'h0) begin
                    if (next_s.tx_reps != `AC_TX_REPS) begin
                        next_s.tx_reps = next_s.tx_reps + 4'h1;
                    end
                    // Sequence ends only after ten full words
                    if (next_s.tx_reps == `AC_TX_REPS) begin
                        unique case (next_s.tx_st)
                            TX_AB: begin
                                next_s.tx_st = TX_B;
                                next_s.tx_reps = 4'h0;
                            end
                            TX_CONT: begin
                                if (s.ctrl[`AC_SEL_LSB +: 2] != AC_SEL_ACONT) begin
                                    next_s.tx_st = TX_IDLE;
                                end
                            end
                            default: next_s.tx_st = TX_IDLE;
                        endcase
                    end
                end
            end
        end
        // Detector, one bit per opportunity
        if (rx_bit_en_in && on) begin
            sh = {rx_bit_in, s.rx_sh[15:1]};
            next_s.rx_sh = sh;
            match = ac_is_word(sh) && (sh[14:9] == s.rx_cand);
            next_s.rx_ones = rx_bit_in ? ((s.rx_ones == `AC_IDLE_ONES) ? s.rx_ones :
                s.rx_ones + 5'h01) : 5'h00;
            if (next_s.rx_ones == `AC_IDLE_ONES && s.rx_ones != `AC_IDLE_ONES && s.rx_seen) begin
                next_s.idle = 1'b1;
                next_s.rx_seen = 1'b0;
            end
            if (!s.rx_lock) begin
                if (ac_is_word(sh)) begin
                    next_s.rx_lock = 1'b1;
                    next_s.rx_phase = 4'h0;
                    next_s.rx_cand = sh[14:9];
                    next_s.rx_hits = 2'h1;
                end
            end else begin
                next_s.rx_phase = s.rx_phase + 4'h1;
                if (s.rx_phase == 4'hf) begin
                    if (s.rx_valid) begin
                        next_s.rx_miss = match ? 2'h0 : s.rx_miss + 2'h1;
                        if (next_s.rx_miss == `AC_RX_MISSES) begin
                            next_s.rx_valid = 1'b0;
                            next_s.rx_lock = 1'b0;
                            next_s.rx_miss = 2'h0;
                        end
                    end else if (match) begin
                        next_s.rx_hits = s.rx_hits + 2'h1;
                        if (next_s.rx_hits == `AC_RX_HITS) begin
                            next_s.rx_valid = 1'b1;
                            next_s.rx_seen = 1'b1;
                            next_s.det = 1'b1;
                            if (next_s.q_cnt == `AC_Q_DEPTH) begin
                                if (s.ovf_arm) begin
                                    next_s.ovf = 1'b1;
                                    next_s.ovf_arm = 1'b0;
                                end
                            end else begin
                                wr_idx = next_s.q_rd + next_s.q_cnt[1:0];
                                next_s.q[wr_idx] = sh[14:9];
                                next_s.q_cnt = next_s.q_cnt + 3'h1;
                            end
                        end
                    end else if (ac_is_word(sh)) begin
                        next_s.rx_cand = sh[14:9];
                        next_s.rx_hits = 2'h1;
                    end else begin
                        next_s.rx_lock = 1'b0;
                    end
                end
            end
        end
        // Rising receive reset bit flushes receiver
        if (take && link.reg_wr && link.reg_addr == `AC_CTRL_OFS &&
            link.reg_wdata[`AC_RX_RST_BIT] && !s.ctrl[`AC_RX_RST_BIT]) begin
            next_s.rx_lock = 1'b0;
            next_s.rx_valid = 1'b0;
            next_s.rx_hits = 2'h0;
            next_s.rx_miss = 2'h0;
            next_s.rx_ones = 5'h00;
            next_s.rx_seen = 1'b0;
            next_s.q_rd = 2'h0;
            next_s.q_cnt = 3'h0;
            next_s.ovf_arm = 1'b1;
            next_s.det = 1'b0;
            next_s.idle = 1'b0;
            next_s.ovf = 1'b0;
        end
    end

    ////////////////////////
    // State register
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s <= '0;
            s.ctrl <= `AC_CTRL_RST;
            s.tx_bit <= 1'b1;
            s.ovf_arm <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

//--- ac_alarm_cfg.svh
// Constants of the far-end alarm code controller
`ifndef AC_ALARM_CFG_SVH
`define AC_ALARM_CFG_SVH
// Device register offsets
`define AC_CTRL_OFS 8'h90
`define AC_STAT_OFS 8'h92
// Control fields
`define AC_WA_LSB 0
`define AC_SEL_LSB 6
`define AC_WB_LSB 8
`define AC_IDLE_IE_BIT 14
`define AC_RX_RST_BIT 15
`define AC_CTRL_RST 16'h0000
// Status fields
`define AC_DET_BIT 0
`define AC_IDLE_BIT 1
`define AC_Q_LSB 8
`define AC_EMPTY_BIT 14
`define AC_OVF_BIT 15
// Counts
`define AC_TX_REPS 4'ha
`define AC_RX_HITS 2'h3
`define AC_RX_MISSES 2'h2
`define AC_IDLE_ONES 5'h10
`define AC_Q_DEPTH 3'h4
`define AC_HOST_IDLE_BITS 8'ha0
// Sn source code that routes the alarm channel
`define AC_SN_FROM_ALARM 2'h1
// Controller APB offsets
`define AC_H_CTRL_OFS 12'h000
`define AC_H_CMD_OFS 12'h004
`define AC_H_STAT_OFS 12'h008
`define AC_H_MASK_OFS 12'h00c
`endif

//--- ac_pkg.sv
// Types and helpers of the far-end alarm code controller
package ac_pkg;
    typedef enum logic [1:0] {AC_SEL_IDLE, AC_SEL_A10, AC_SEL_AB10, AC_SEL_ACONT} ac_sel_t;
    typedef enum logic [2:0] {TX_IDLE, TX_A, TX_AB, TX_B, TX_CONT} ac_tx_t;
    typedef enum logic [2:0] {H_IDLE, H_PARK, H_WAIT, H_WRITE, H_RST_SET, H_RST_CLR,
        H_READ} ac_host_t;

    // Code word, bit 0 goes on the line first
    function automatic logic [15:0] ac_word(input logic [5:0] d);
        ac_word = {1'b0, d, 1'b0, 8'hff};
    endfunction

    // True when a 16-bit window holds a code word
    function automatic logic ac_is_word(input logic [15:0] w);
        ac_is_word = (w[7:0] == 8'hff) && !w[8] && !w[15];
    endfunction
endpackage

//--- ac_link_if.sv
// Register port between the controller and the alarm code device
`timescale 1ns/1ps
`default_nettype none
interface ac_link_if;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic reg_ack;
    logic master_irq_mask;
    logic alarm_irq;
    modport dev (input reg_addr, reg_wr, reg_rd, reg_wdata, master_irq_mask,
        output reg_rdata, reg_ack, alarm_irq);
    modport ctl (output reg_addr, reg_wr, reg_rd, reg_wdata, master_irq_mask,
        input reg_rdata, reg_ack, alarm_irq);
endinterface
`default_nettype wire

//--- ac_alarm_ctl.sv
// Controller end: APB registers that drive the alarm code device
`include "ac_alarm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ac_alarm_ctl import ac_pkg::*; (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit opportunity tick of the framer
    input wire logic tx_bit_en_in,
    // Interrupt towards the CPU
    output logic irq_out,
    // Device side
    ac_link_if.ctl link
);
    typedef struct packed {
        ac_host_t st;
        logic [15:0] want;
        logic [15:0] cur;
        logic [15:0] wdata;
        logic [7:0] idle_bits;
        logic [15:0] dev_stat;
        logic mask;
    } ac_ctl_state_t;

    ac_ctl_state_t s;
    ac_ctl_state_t next_s;
    logic busy;
    logic wr_go;
    logic [15:0] w;

    ////////////////////////
    // Bus answer; orders stall while a device sequence runs
    assign busy = (s.st != H_IDLE);
    assign pready = !(busy && pwrite && paddr inside {`AC_H_CTRL_OFS, `AC_H_CMD_OFS});
    assign pslverr = !(paddr inside {`AC_H_CTRL_OFS, `AC_H_CMD_OFS, `AC_H_STAT_OFS,
        `AC_H_MASK_OFS});
    assign wr_go = psel && penable && pready && pwrite;
    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == `AC_H_CTRL_OFS) begin
            prdata[15:0] = s.cur;
        end else if (paddr == `AC_H_STAT_OFS) begin
            prdata = {14'h0000, irq_out, busy, s.dev_stat};
        end else if (paddr == `AC_H_MASK_OFS) begin
            prdata[0] = s.mask;
        end
    end

    ////////////////////////
    // Device port
    assign link.reg_wr = s.st inside {H_PARK, H_WRITE, H_RST_SET, H_RST_CLR};
    assign link.reg_rd = (s.st == H_READ);
    assign link.reg_addr = (s.st == H_READ) ? `AC_STAT_OFS : `AC_CTRL_OFS;
    assign link.reg_wdata = s.wdata;
    assign link.master_irq_mask = s.mask;
    assign irq_out = link.alarm_irq;

    ////////////////////////
    // Sequencer
    always_comb begin
        next_s = s;
        w = {1'b0, pwdata[14:0]};
        // Idle bits counted while select is 00
        if (s.cur[`AC_SEL_LSB +: 2] != 2'h0) begin
            next_s.idle_bits = 8'h00;
        end else if (tx_bit_en_in && s.idle_bits != `AC_HOST_IDLE_BITS) begin
            next_s.idle_bits = s.idle_bits + 8'h01;
        end
        if (wr_go && paddr == `AC_H_MASK_OFS) begin
            next_s.mask = pwdata[0];
        end
        unique case (s.st)
            H_IDLE: begin
                if (wr_go && paddr == `AC_H_CTRL_OFS && w != s.cur) begin
                    next_s.want = w;
                    if (s.cur[`AC_SEL_LSB +: 2] != 2'h0) begin
                        // Park at 00 before any change
                        next_s.st = H_PARK;
                        next_s.wdata = s.cur;
                        next_s.wdata[`AC_SEL_LSB +: 2] = 2'h0;
                    end else begin
                        next_s.st = H_WAIT;
                    end
                end else if (wr_go && paddr == `AC_H_CMD_OFS && pwdata[1]) begin
                    next_s.st = H_RST_SET;
                    next_s.wdata = s.cur;
                    next_s.wdata[`AC_RX_RST_BIT] = 1'b1;
                end else if (wr_go && paddr == `AC_H_CMD_OFS && pwdata[0]) begin
                    next_s.st = H_READ;
                end
            end
            H_PARK: begin
                if (link.reg_ack) begin
                    next_s.cur = s.wdata;
                    next_s.st = H_WAIT;
                end
            end
            H_WAIT: begin
                // Non-idle select only after ten idle words
                if (s.want[`AC_SEL_LSB +: 2] == 2'h0 || s.idle_bits == `AC_HOST_IDLE_BITS) begin
                    next_s.st = H_WRITE;
                    next_s.wdata = s.want;
                end
            end
            H_WRITE: begin
                if (link.reg_ack) begin
                    next_s.cur = s.wdata;
                    next_s.st = H_IDLE;
                end
            end
            H_RST_SET: begin
                if (link.reg_ack) begin
                    next_s.st = H_RST_CLR;
                    next_s.wdata = s.cur;
                end
            end
            H_RST_CLR: begin
                if (link.reg_ack) begin
                    next_s.st = H_IDLE;
                end
            end
            H_READ: begin
                if (link.reg_ack) begin
                    next_s.dev_stat = link.reg_rdata;
                    next_s.st = H_IDLE;
                end
            end
            default: next_s.st = H_IDLE;
        endcase
    end

    ////////////////////////
    // State register
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s <= '0;
            s.cur <= `AC_CTRL_RST;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

//--- ac_alarm_monitor.sv
// Assertions on the controller to device link
`include "ac_alarm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ac_alarm_monitor (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Link signals
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic master_irq_mask,
    input wire logic alarm_irq
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    ////////////////////////
    // Status read answered in this cycle
    wire logic st_rd = reg_ack && reg_rd && (reg_addr == `AC_STAT_OFS);

    ////////////////////////
    // Link handshake
    a_ack_pulse: assert property (reg_ack |=> !reg_ack)
        else $error("ack too long");
    a_ack_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
        else $error("stray ack");
    a_req_answer: assert property (((reg_wr || reg_rd) && !reg_ack) |=>
        (reg_ack && $stable(reg_addr) && $stable(reg_wr)))
        else $error("late ack");
    a_rdata_hold: assert property (!(reg_ack && reg_rd) |-> $stable(reg_rdata))
        else $error("rdata moved");

    ////////////////////////
    // Flags, queue and interrupt
    a_irq_masked: assert property (!master_irq_mask |-> !alarm_irq)
        else $error("irq masked");
    a_det_irq: assert property (st_rd && reg_rdata[`AC_DET_BIT] && $past(master_irq_mask)
        |-> $past(alarm_irq))
        else $error("det no irq");
    a_det_queued: assert property (st_rd && reg_rdata[`AC_DET_BIT] |-> !reg_rdata[14])
        else $error("det, queue empty");
    a_ovf_full: assert property (st_rd && reg_rdata[`AC_OVF_BIT] |-> !reg_rdata[14])
        else $error("ovf, queue empty");
    a_rst_pulse: assert property (reg_ack && reg_wr && reg_addr == `AC_CTRL_OFS
        && reg_wdata[15] |-> ##[1:8] (reg_wr && reg_addr == `AC_CTRL_OFS && !reg_wdata[15]))
        else $error("reset bit stuck");

    // Main scenarios reached
    cover property (st_rd && reg_rdata[`AC_OVF_BIT]);
    cover property (st_rd && reg_rdata[`AC_DET_BIT]);
    cover property (reg_wr && reg_wdata[15]);
endmodule
`default_nettype wire

//--- far_end_alarm_code_controller_test.sv
// Bench for both ends of the alarm code controller
`include "ac_alarm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module far_end_alarm_code_controller_test;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [11:0] paddr = 12'h0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq_out, tx_bit_out, sn_out;
    logic tx_en = 1'b0, rx_en = 1'b0, t3 = 1'b0, cbit = 1'b0, loop = 1'b1, drv_bit = 1'b1;
    logic [1:0] sn_sel = 2'h1;
    logic [1:0] tick = 2'h0;
    int bad_count = 0, n_checks = 0, ones_run = 0;
    bit logv[$];
    bit zseen = 1'b0;
    logic serr;
    logic [31:0] r;
    logic [15:0] st, wa, wx;
    logic [5:0] a, b;
    logic [15:0] sq[$];

    ////////////////////////
    // Both ends across the link, and the checker
    ac_link_if link_i ();
    ac_alarm_ctl ac_alarm_ctl_i (.core_clk_in, .sys_rst_in, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .tx_bit_en_in(tx_en), .irq_out,
        .link(link_i.ctl));
    ac_alarm_device ac_alarm_device_i (.core_clk_in, .sys_rst_in, .link(link_i.dev),
        .t3_mode_in(t3), .cbit_parity_in(cbit), .sn_source_sel_in(sn_sel),
        .tx_bit_en_in(tx_en), .tx_bit_out, .sn_from_alarm_out(sn_out),
        .rx_bit_en_in(rx_en), .rx_bit_in(loop ? tx_bit_out : drv_bit));
    ac_alarm_monitor ac_alarm_monitor_i (.core_clk_in, .sys_rst_in,
        .reg_addr(link_i.reg_addr), .reg_wr(link_i.reg_wr), .reg_rd(link_i.reg_rd),
        .reg_wdata(link_i.reg_wdata), .reg_rdata(link_i.reg_rdata), .reg_ack(link_i.reg_ack),
        .master_irq_mask(link_i.master_irq_mask), .alarm_irq(link_i.alarm_irq));

    // Clock
    always #2 core_clk_in = ~core_clk_in;

    // Line strobe every four cycles, receive one later
    always @(posedge core_clk_in) begin
        tick <= tick + 2'h1;
        tx_en <= (tick == 2'h3);
        rx_en <= tx_en;
    end

    // Log of the transmitted line bits
    always @(posedge core_clk_in) begin
        if (rx_en) begin
            logv.push_back(tx_bit_out);
            ones_run <= tx_bit_out ? ones_run + 1 : 0;
            if (!tx_bit_out) zseen <= 1'b1;
        end
    end

    ////////////////////////
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [11:0] ad, input logic wr, input logic [31:0] wd);
        @(posedge core_clk_in);
        paddr <= ad;
        pwrite <= wr;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge core_clk_in);
        penable <= 1'b1;
        // Values read here are those sampled at this edge
        do @(posedge core_clk_in); while (pready !== 1'b1);
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Device status via the controller
    task automatic rd_stat;
        int k;
        apb(`AC_H_CMD_OFS, 1'b1, 32'h1);
        r = 32'h10000;
        for (k = 0; k < 50 && r[16]; k++) apb(`AC_H_STAT_OFS, 1'b0, 32'h0);
        st = r[15:0];
    endtask

    function automatic logic [15:0] expw(input logic [5:0] d);
        return {1'b0, d, 1'b0, 8'hff};
    endfunction

    function automatic logic [15:0] getw(input int i);
        for (int k = 0; k < 16; k++) getw[k] = (i + k >= 0 && i + k < logv.size()) ? logv[i + k] : 1'bx;
    endfunction

    // Write control, wait for idle ones
    task automatic tx_run(input logic [15:0] cv, input bit cont);
        int k;
        logv.delete();
        zseen = 1'b0;
        apb(`AC_H_CTRL_OFS, 1'b1, {16'h0, cv});
        for (k = 0; cont && k < 5000 && !(zseen && logv.size() > 500); k++) @(posedge core_clk_in);
        if (cont) apb(`AC_H_CTRL_OFS, 1'b1, {16'h0, cv & 16'hff3f});
        for (k = 0; k < 20000 && !(zseen && ones_run >= 40); k++) @(posedge core_clk_in);
    endtask

    // Count logged words; na < 0 means ten or more
    task automatic check_tx(input logic [5:0] da, input logic [5:0] db, input int na, input int nb);
        int i = 0, ka = 0, kb = 0;
        while (i < logv.size() && logv[i]) i++;
        i = i - 8;
        chk(getw(i), expw(da));
        while (getw(i) === expw(da)) begin
            ka++;
            i += 16;
        end
        while (nb > 0 && getw(i) === expw(db)) begin
            kb++;
            i += 16;
        end
        if (na < 0) chk(ka >= 10, 1);
        else chk(ka, na);
        chk(kb, nb);
        chk(getw(i), 16'hffff);
    endtask

    // Play queued words on the receive line, then ones
    task automatic rx_play;
        repeat (3) sq.push_back(16'hffff);
        foreach (sq[n]) begin
            for (int k = 0; k < 16; k++) begin
                @(posedge core_clk_in iff tx_en);
                drv_bit <= sq[n][k];
            end
        end
        sq.delete();
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////
    // Watchdog
    initial begin
        repeat (60000) @(posedge core_clk_in);
        bad_count++;
        wrap_up();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h6bc3));
        repeat (10) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        apb(`AC_H_CTRL_OFS, 1'b0, 32'h0);
        chk(r, 32'h0);
        apb(12'h010, 1'b0, 32'h0);
        chk({r[30:0], serr}, 32'h1);
        apb(`AC_H_MASK_OFS, 1'b1, 32'h1);
        apb(`AC_H_MASK_OFS, 1'b0, 32'h0);
        chk(r, 32'h1);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk_in);
            t3 <= i[2];
            sn_sel <= i[1:0];
            cbit <= 1'($urandom);
            @(posedge core_clk_in);
            chk(sn_out, !i[2] && i[1:0] == 2'h1);
        end
        t3 <= 1'b0;
        sn_sel <= 2'h1;
        $display("test registers and routing done");
        // Ten of word A, looped back to the receiver
        a = 6'($urandom);
        b = a ^ 6'($urandom_range(63, 1));
        tx_run({8'h0, 2'h1, a}, 1'b0);
        check_tx(a, b, 10, 0);
        chk(irq_out, 1);
        rd_stat();
        chk(st & 16'hff03, {2'h0, a, 8'h03});
        chk(irq_out, 0);
        rd_stat();
        chk(st & 16'hc003, 16'h4000);
        $display("test word a done");
        // Ten of A then ten of B, from a non-idle select
        tx_run({2'h0, b, 2'h2, a}, 1'b0);
        check_tx(a, b, 10, 10);
        rd_stat();
        chk(st & 16'hff03, {2'h0, a, 8'h03});
        rd_stat();
        chk(st & 16'hff03, {2'h0, b, 8'h00});
        $display("test words a and b done");
        // Continuous A, stopped by returning to idle
        tx_run({8'h0, 2'h3, b}, 1'b1);
        check_tx(b, a, -1, 0);
        rd_stat();
        chk(st & 16'hc001, 16'h0001);
        rd_stat();
        chk(st & 16'hc003, 16'h4000);
        $display("test continuous done");
        // Receive debounce with the line driven directly
        loop <= 1'b0;
        a = 6'($urandom);
        wa = expw(a);
        wx = expw(a ^ 6'h15);
        sq = '{wa, wa, wx, wa, wa, wx, wa};
        rx_play();
        rd_stat();
        chk(st & 16'hc001, 16'h4000);
        sq = '{wa, wa, wa, wx, wa, wa, wa, expw(a ^ 6'h2a), wx, wa, wa, wa};
        rx_play();
        rd_stat();
        chk(st & 16'hff03, {2'h0, a, 8'h03});
        rd_stat();
        chk(st & 16'hff03, {2'h0, a, 8'h00});
        rd_stat();
        chk(st & 16'hc003, 16'h4000);
        $display("test debounce done");
        // Five words into a four-deep queue, then a receive reset
        for (int i = 0; i < 5; i++) repeat (5) sq.push_back(expw(a ^ 6'(i)));
        rx_play();
        rd_stat();
        chk(st & 16'hff03, {2'h2, a, 8'h03});
        for (int i = 1; i < 4; i++) begin
            rd_stat();
            chk(st & 16'hff00, {2'h0, a ^ 6'(i), 8'h00});
        end
        rd_stat();
        chk(st & 16'hc000, 16'h4000);
        repeat (3) sq.push_back(expw(a ^ 6'h5));
        rx_play();
        apb(`AC_H_CMD_OFS, 1'b1, 32'h2);
        rd_stat();
        chk(st & 16'hc003, 16'h4000);
        $display("test overflow and reset done");
        // T3 without C-bit parity stays deaf, with it listens
        t3 <= 1'b1;
        cbit <= 1'b0;
        repeat (4) sq.push_back(wa);
        rx_play();
        rd_stat();
        chk(st & 16'hc001, 16'h4000);
        cbit <= 1'b1;
        repeat (3) sq.push_back(wa);
        rx_play();
        rd_stat();
        chk(st & 16'hff01, {2'h0, a, 8'h01});
        $display("test framing mode done");
        wrap_up();
    end
endmodule
`default_nettype wire
